// ---- design/adc_status_params.svh ----
`ifndef ADC_STATUS_PARAMS_SVH
`define ADC_STATUS_PARAMS_SVH

// Register indices on the plain register port
`define ADDR_STATUS      4'h0
`define ADDR_CONTROL     4'h1
`define ADDR_OPTION      4'h2
`define ADDR_IRQ_STATUS  4'h3
`define ADDR_IRQ_MASK    4'h4
`define ADDR_PORT        4'h5

// analog_status_flags field positions
`define ST_RAMP_FLAG     7
`define ST_PAIR_FLAG     6
`define ST_RAMP_CLR      5
`define ST_PAIR_CLR      4
`define ST_OFFSET_EN     3
`define ST_ROUTE_EN      2
`define ST_RAMP_LIVE     1
`define ST_PAIR_LIVE     0

// analog_control_reg field positions
`define CT_CHARGE        7
`define CT_MODE_HI       6
`define CT_MODE_LO       5
`define CT_CAPTURE_CMP   4
`define CT_IRQ_EN        3
`define CT_RAMP_PWR      2
`define CT_PAIR_PWR      1
`define CT_SOURCE_EN     0

// Extra control register: hold bits and port bit 4 controls
`define PT_SAMPLE_HOLD   0
`define PT_DIFF_HOLD     1
`define PT_DIR4          2
`define PT_DATA4         3
`define PT_LEVEL         4

// Event interrupt status / mask bits
`define EV_RAMP          0
`define EV_PAIR          1

`define RESET_BYTE       8'h00

`endif

// ---- design/adc_status_pkg.sv ----
package adc_status_pkg;

	typedef struct packed {
		logic [2:0] s;
	} sync3_t;

	typedef enum logic [1:0] {
		EV_IDLE_S = 2'b01,
		EV_HIGH_S = 2'b10
	} edge_state_t;

endpackage

// ---- design/cmp_event_if.sv ----
`timescale 1ns/1ps
interface cmp_event_if;
	logic live;
	logic rise;
	modport producer (output live, output rise);
	modport consumer (input live, input rise);
endinterface

// ---- design/cmp_edge_detect.sv ----
`timescale 1ns/1ps
`include "adc_status_params.svh"
module cmp_edge_detect
	import adc_status_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         cmp_raw_i,
	input  wire logic         power_i,
	cmp_event_if.producer     ev
);
	typedef struct packed {
		sync3_t      sync;
		logic        live;
		edge_state_t st;
	} edge_reg_t;

	edge_reg_t q;
	edge_reg_t d;
	logic      agree;

	always_comb begin
		d     = q;
		agree = (q.sync.s[1] == q.sync.s[2]);
		// Powered-down comparator reads constant low
		d.sync.s = {q.sync.s[1:0], cmp_raw_i & power_i};
		if (!power_i) begin
			d.live = 1'b0;
		end else if (agree) begin
			d.live = q.sync.s[2];
		end
		// Track the registered level, so the rise pulse stands exactly one cycle
		unique case (q.st)
			EV_IDLE_S: if (q.live) d.st = EV_HIGH_S;
			EV_HIGH_S: if (!q.live) d.st = EV_IDLE_S;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q <= '{sync: '{s: 3'h0}, live: 1'b0, st: EV_IDLE_S};
		end else begin
			q <= d;
		end
	end

	assign ev.live = q.live;
	// One pulse per low-to-high transition of the filtered output
	assign ev.rise = (q.st == EV_IDLE_S) && q.live;
endmodule // cmp_edge_detect

// ---- design/adc_status_ctrl.sv ----
`timescale 1ns/1ps
`include "adc_status_params.svh"

// Behaviour
// - Whole analog status register clears to zero on device reset.
// - Rising edge of comparator 2 sets ramp_cmp_flag until cleared.
// - Rising edge of comparator 1 sets pair_cmp_flag until cleared.
// - Writing one to a clear strobe clears its flag; strobes read zero.
// - sample_offset_en acts and reads only while option_enable is set.
// - cmp_out_route_en acts and reads only while option_enable is set.
// - Offset control asserted only when enabled and both hold bits clear.
// - Either hold bit grounds capacitor bottom plate, overriding offset.
// - Routed port bit 4 output is OR of comparator 1, data and level.
// - ramp_cmp_live shows present comparator 2 output, zero when disabled.
// - pair_cmp_live shows present comparator 1 output, zero when disabled.
// - Charge/discharge controls affect ramp pin only with charge_source_en.
// - Clearing charge_source_en turns off charge and discharge at once.
// - With analog_irq_en set, either latched flag raises analog interrupt.
// - capture_from_cmp selects ramp_cmp_flag as timer capture trigger.
module adc_status_ctrl
	import adc_status_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       ramp_cmp_raw_i,
	input  wire logic       pair_cmp_raw_i,
	input  wire logic       capture_pin_i,
	output logic            charge_on_o,
	output logic            discharge_on_o,
	output logic            ramp_cmp_pwr_o,
	output logic            pair_cmp_pwr_o,
	output logic            sample_offset_o,
	output logic            plate_ground_o,
	output logic            port_b_bit4_pin_o,
	output logic            port_b_bit4_pin_oe_o,
	output logic            capture_trig_o,
	output logic            analog_irq_o,
	output logic            irq_o
);
	typedef struct packed {
		logic       ramp_flag;
		logic       pair_flag;
		logic       offset_en;
		logic       route_en;
		logic [7:0] control;
		logic       option_enable;
		logic [4:0] port;
		logic [1:0] ev_status;
		logic [1:0] ev_mask;
		logic [7:0] rdata;
		logic       charge_on;
		logic       discharge_on;
		logic       sample_offset;
		logic       plate_ground;
		logic       pin_out;
		logic       pin_oe;
		logic       capture;
		logic       analog_irq;
		logic       irq;
	} state_t;

	state_t q;
	state_t d;

	cmp_event_if ramp_ev ();
	cmp_event_if pair_ev ();

	cmp_edge_detect u_ramp (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.cmp_raw_i (ramp_cmp_raw_i),
		.power_i   (q.control[`CT_RAMP_PWR]),
		.ev        (ramp_ev)
	);

	cmp_edge_detect u_pair (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.cmp_raw_i (pair_cmp_raw_i),
		.power_i   (q.control[`CT_PAIR_PWR]),
		.ev        (pair_ev)
	);

	function automatic logic [7:0] status_view(input state_t s, input logic rl, input logic pl);
		logic [7:0] v;
		v                = 8'h00;
		v[`ST_RAMP_FLAG] = s.ramp_flag;
		v[`ST_PAIR_FLAG] = s.pair_flag;
		v[`ST_OFFSET_EN] = s.offset_en & s.option_enable;
		v[`ST_ROUTE_EN]  = s.route_en & s.option_enable;
		v[`ST_RAMP_LIVE] = rl;
		v[`ST_PAIR_LIVE] = pl;
		return v; // Clear strobes read as zero
	endfunction

	logic wr_status;
	logic offset_eff;
	logic route_eff;
	logic src_en;
	logic held;

	always_comb begin
		d         = q;
		wr_status = wr_i && (addr_i == `ADDR_STATUS);

		// Clear first, then set: an edge in the same cycle wins
		if (wr_status && wdata_i[`ST_RAMP_CLR]) d.ramp_flag = 1'b0;
		if (wr_status && wdata_i[`ST_PAIR_CLR]) d.pair_flag = 1'b0;
		if (ramp_ev.rise) d.ramp_flag = 1'b1;
		if (pair_ev.rise) d.pair_flag = 1'b1;

		if (wr_status) begin
			d.offset_en = wdata_i[`ST_OFFSET_EN];
			d.route_en  = wdata_i[`ST_ROUTE_EN];
		end
		if (wr_i && addr_i == `ADDR_CONTROL) d.control = wdata_i;
		if (wr_i && addr_i == `ADDR_OPTION) d.option_enable = wdata_i[0];
		if (wr_i && addr_i == `ADDR_PORT) d.port = wdata_i[4:0];
		if (wr_i && addr_i == `ADDR_IRQ_MASK) d.ev_mask = wdata_i[1:0];
		if (wr_i && addr_i == `ADDR_IRQ_STATUS) d.ev_status = q.ev_status & ~wdata_i[1:0];
		// Sticky event bits; set beats write-one-clear
		if (ramp_ev.rise) d.ev_status[`EV_RAMP] = 1'b1;
		if (pair_ev.rise) d.ev_status[`EV_PAIR] = 1'b1;

		// Mode bits in control[6:5] are stored only; mode sequencing lives elsewhere
		src_en         = d.control[`CT_SOURCE_EN];
		d.charge_on    = src_en & d.control[`CT_CHARGE];
		d.discharge_on = src_en & ~d.control[`CT_CHARGE];

		offset_eff      = d.offset_en & d.option_enable;
		route_eff       = d.route_en & d.option_enable;
		held            = d.port[`PT_SAMPLE_HOLD] | d.port[`PT_DIFF_HOLD];
		d.plate_ground  = held | ~offset_eff;
		d.sample_offset = offset_eff & ~held;

		d.pin_oe  = d.port[`PT_DIR4];
		if (route_eff && d.port[`PT_DIR4]) begin
			d.pin_out = pair_ev.live | d.port[`PT_DATA4] | d.port[`PT_LEVEL];
		end else begin
			d.pin_out = d.port[`PT_DATA4];
		end

		// Flag, not the pin, feeds the capture path when selected
		d.capture = d.control[`CT_CAPTURE_CMP] ? d.ramp_flag : capture_pin_i;
		d.analog_irq = d.control[`CT_IRQ_EN] & (d.ramp_flag | d.pair_flag);
		d.irq        = |(d.ev_status & d.ev_mask);

		d.rdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				`ADDR_STATUS:     d.rdata = status_view(q, ramp_ev.live, pair_ev.live);
				`ADDR_CONTROL:    d.rdata = q.control;
				`ADDR_OPTION:     d.rdata = {7'h00, q.option_enable};
				`ADDR_IRQ_STATUS: d.rdata = {6'h00, q.ev_status};
				`ADDR_IRQ_MASK:   d.rdata = {6'h00, q.ev_mask};
				`ADDR_PORT:       d.rdata = {3'h0, q.port};
				default:          d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdata_o              = q.rdata;
	assign charge_on_o          = q.charge_on;
	assign discharge_on_o       = q.discharge_on;
	assign ramp_cmp_pwr_o       = q.control[`CT_RAMP_PWR];
	assign pair_cmp_pwr_o       = q.control[`CT_PAIR_PWR];
	assign sample_offset_o      = q.sample_offset;
	assign plate_ground_o       = q.plate_ground;
	assign port_b_bit4_pin_o    = q.pin_out;
	assign port_b_bit4_pin_oe_o = q.pin_oe;
	assign capture_trig_o       = q.capture;
	assign analog_irq_o         = q.analog_irq;
	assign irq_o                = q.irq;
endmodule // adc_status_ctrl

// ---- verification/adc_status_chk.sv ----
`timescale 1ns/1ps
module adc_status_chk (
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       ramp_cmp_raw_i,
	input wire logic       charge_on_o,
	input wire logic       discharge_on_o,
	input wire logic       ramp_cmp_pwr_o,
	input wire logic       sample_offset_o,
	input wire logic       plate_ground_o,
	input wire logic       port_b_bit4_pin_oe_o,
	input wire logic       analog_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_off;
		wr_i && addr_i == 4'h1 && !wdata_i[0] |=> !charge_on_o && !discharge_on_o;
	endproperty
	a_off: assert property (p_off) else $error("source on");
	property p_chg;
		wr_i && addr_i == 4'h1 && wdata_i[0] |=>
			charge_on_o == $past(wdata_i[7]) && discharge_on_o != $past(wdata_i[7]);
	endproperty
	a_chg: assert property (p_chg) else $error("charge ctl");
	property p_hold;
		wr_i && addr_i == 4'h5 && wdata_i[1:0] != 2'h0 |=> plate_ground_o && !sample_offset_o;
	endproperty
	a_hold: assert property (p_hold) else $error("hold plate");
	property p_opt;
		wr_i && addr_i == 4'h2 && !wdata_i[0] |=> !sample_offset_o;
	endproperty
	a_opt: assert property (p_opt) else $error("offset gate");
	property p_irq;
		wr_i && addr_i == 4'h1 && !wdata_i[3] |=> !analog_irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq gate");
	property p_clr;
		rd_i && addr_i == 4'h0 |=> rdata_o[5:4] == 2'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("strobe read");
	property p_dir;
		wr_i && addr_i == 4'h5 |=> port_b_bit4_pin_oe_o == $past(wdata_i[2]);
	endproperty
	a_dir: assert property (p_dir) else $error("pin enable");
	property p_dead;
		(!ramp_cmp_pwr_o)[*6] ##1 rd_i && addr_i == 4'h0 |=> !rdata_o[1];
	endproperty
	a_dead: assert property (p_dead) else $error("live unpowered");
	property p_edge;
		ramp_cmp_pwr_o && $rose(ramp_cmp_raw_i) ##1 (ramp_cmp_raw_i && ramp_cmp_pwr_o && !wr_i)[*7]
			##1 rd_i && addr_i == 4'h0 |=> rdata_o[7];
	endproperty
	a_edge: assert property (p_edge) else $error("flag missed");
endmodule // adc_status_chk

bind adc_status_ctrl adc_status_chk u_adc_status_chk (.*);

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	logic       clk_i = 1'h0, rst_b_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
	logic       ramp_cmp_raw_i = 1'h0, pair_cmp_raw_i = 1'h0, capture_pin_i = 1'h0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o, v;
	logic       charge_on_o, discharge_on_o, ramp_cmp_pwr_o, pair_cmp_pwr_o, irq_o;
	logic       sample_offset_o, plate_ground_o, capture_trig_o, analog_irq_o;
	logic       port_b_bit4_pin_o, port_b_bit4_pin_oe_o;
	int         mismatches = 0, n_compared = 0, seed = 50;

	adc_status_ctrl u_adc_status_ctrl (.*);

	always #10 clk_i = ~clk_i;

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1 `CHK(rdata_o, e)
	endtask

	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		end_sim;
	end

	initial begin
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'h1;
		for (int i = 0; i < 8; i++) rd(4'(i), 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			capture_pin_i <= v[4];
			wr(4'h1, v);
			rd(4'h1, v);
			`CHK(charge_on_o, v[7] & v[0])
			`CHK(discharge_on_o, !v[7] & v[0])
			`CHK({ramp_cmp_pwr_o, pair_cmp_pwr_o}, v[2:1])
			if (v[7]) wr(4'h1, 8'h01);
		end
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h0C);
		rd(4'h0, 8'h00);
		wr(4'h2, 8'h01);
		rd(4'h0, 8'h0C);
		`CHK({sample_offset_o, plate_ground_o}, 2'h2)
		for (int h = 1; h < 4; h++) begin
			wr(4'h5, 8'(h));
			#1 `CHK({sample_offset_o, plate_ground_o}, 2'h1)
		end
		wr(4'h5, 8'h04);
		wr(4'h1, 8'h06);
		wr(4'h0, 8'h3C);
		pair_cmp_raw_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		// Clear strobe lands on the very edge that sets the flag
		wr(4'h0, 8'h1C);
		#1 `CHK({port_b_bit4_pin_o, port_b_bit4_pin_oe_o}, 2'h3)
		rd(4'h0, 8'h4D);
		wr(4'h0, 8'h1C);
		rd(4'h0, 8'h0D);
		pair_cmp_raw_i <= 1'h0;
		wr(4'h1, 8'h0E);
		ramp_cmp_raw_i <= 1'h1;
		repeat (7) @(posedge clk_i);
		rd(4'h0, 8'h8E);
		`CHK(analog_irq_o, 1'h1)
		wr(4'h4, 8'h01);
		rd(4'h3, 8'h03);
		`CHK(irq_o, 1'h1)
		wr(4'h3, 8'h01);
		rd(4'h3, 8'h02);
		`CHK(irq_o, 1'h0)
		wr(4'h0, 8'h2C);
		rd(4'h0, 8'h0E);
		`CHK(analog_irq_o, 1'h0)
		wr(4'h1, 8'h00);
		repeat (6) @(posedge clk_i);
		rd(4'h0, 8'h0C);
		ramp_cmp_raw_i <= 1'h0;
		capture_pin_i <= 1'h1;
		wr(4'h1, 8'h10);
		rd(4'h1, 8'h10);
		`CHK(capture_trig_o, 1'h0)
		wr(4'h1, 8'h00);
		rd(4'h1, 8'h00);
		`CHK(capture_trig_o, 1'h1)
		end_sim;
	end
endmodule // tb
